// ### rtl/dop_output_module.sv
/*
  Output module control: data word, configuration, power bits, PWM
  step divider and switch routing onto the two module output pins.
  Assumes a simple CPU register port, synchronous to core_clk; analog
  switches and amplifiers outside act on the registered controls here.
*/
// Notes on behaviour
// RULE1: PWM duty is top twelve data bits
// RULE2: Zero duty code gives exactly half high
// RULE3: Most negative code gives zero high time
// RULE4: Most positive code gives 4095 of 4096
// RULE5: Each step lasts 2 us, 4096 steps
// RULE6: New duty applied only at period end
// RULE7: Large amp driving DAC becomes unity buffer
// RULE8: Then PWM takes small pin, small amp off
// RULE9: Small amp driving DAC becomes unity buffer
// RULE10: Then PWM takes large pin, large amp off
// RULE11: At most two functions on two pins
// RULE12: Fixed priority resolves conflicting switch requests
// RULE13: DAC reference is supply or twice pin
// RULE14: Free amp is buffer or stand-alone amplifier
// RULE15: Power bits live at address 31h
// RULE16: DAC takes whole word, zero is midscale
// RULE17: Unpowered DAC or amp goes high impedance
// RULE18: Free-running counter compared with offset duty
// RULE19: After reset PWM off, pins undriven
`timescale 1ns/1ns
`include "dop_regs.svh"
module dop_output_module
  import dop_pkg::*;
#(
  parameter int STEP_CYC = `PWM_STEP_CYC
)(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  output logic [15:0] reg_rdata,
  output logic [15:0] dac_code,
  output logic dac_enable,
  output logic dac_ref_ext,
  output logic sm_amp_enable,
  output logic sm_amp_buffer,
  output logic sm_amp_from_dac,
  output logic amp_inverting_pin_sm_hiz,
  output logic lg_amp_enable,
  output logic lg_amp_buffer,
  output logic lg_amp_from_dac,
  output logic amp_inverting_pin_lg_hiz,
  output pin_src_t small_amp_out_pin_src,
  output pin_src_t large_amp_out_pin_src,
  output logic small_amp_out_pin_pwm,
  output logic large_amp_out_pin_pwm
);
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);
  localparam logic [7:0] STEP_GAP = 8'(STEP_CYC);

  logic [15:0] power_q, power_d;
  logic [15:0] data_q, data_d;
  logic [15:0] config_q, config_d;
  logic [15:0] rdata_q, rdata_d;
  logic [7:0] div_q, div_d;
  logic step_q, step_d;
  pin_src_t sm_src_q, sm_src_d, lg_src_q, lg_src_d;
  logic [5:0] ctl_q, ctl_d;
  logic sm_pwm_q, sm_pwm_d, lg_pwm_q, lg_pwm_d;
  logic dac_on, pwm_on, drv_large, sm_pwr, lg_pwr;
  logic [15:0] status_w;

  pwm_if pw ();

  // Pin source decision; DAC first, then PWM, then the free amp
  function automatic pin_src_t pin_src(input logic dac_here, input logic pwm_here,
                                       input logic amp_ok);
    if (dac_here) begin
      pin_src = SRC_DAC;
    end else if (pwm_here) begin
      pin_src = SRC_PWM;
    end else if (amp_ok) begin
      pin_src = SRC_AMP;
    end else begin
      pin_src = SRC_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register file next values
  always_comb begin
    power_d = power_q;
    data_d = data_q;
    config_d = config_q;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_POWER_ON: power_d = reg_wdata; // RULE15
        `ADDR_DATA_WORD: data_d = reg_wdata;
        `ADDR_CONFIG: config_d = reg_wdata;
        default: power_d = power_q;
      endcase
    end
    // Read data is registered; unmapped addresses read as zero
    case (reg_addr)
      `ADDR_POWER_ON: rdata_d = power_q;
      `ADDR_DATA_WORD: rdata_d = data_q;
      `ADDR_CONFIG: rdata_d = config_q;
      `ADDR_STATUS: rdata_d = status_w;
      default: rdata_d = 16'h0000;
    endcase
  end

  assign status_w = {10'h000, lg_src_q, sm_src_q, pw.level, step_q};

  ////////////////////////////////////////////////////////////////////////
  // Step divider: one enable pulse per PWM time step
  always_comb begin
    div_d = div_q + 8'h01;
    step_d = 1'b0;
    if (!pwm_on) begin
      div_d = 8'h00;
    end else if (div_q == STEP_LAST) begin
      div_d = 8'h00;
      step_d = 1'b1; // RULE5
    end
  end

  assign pw.step = step_q;
  assign pw.enable = pwm_on;
  assign pw.duty_word = data_q[15:4]; // RULE1

  pwm_core u_pwm_core (
    .core_clk(core_clk),
    .nrst(nrst),
    .pw(pw)
  );

  ////////////////////////////////////////////////////////////////////////
  // Switch routing; a powered-down circuit is never routed
  assign sm_pwr = power_q[`PWR_SM_AMP_BIT];
  assign lg_pwr = power_q[`PWR_LG_AMP_BIT];
  assign drv_large = config_q[`CFG_DRV_LARGE];
  assign dac_on = config_q[`CFG_DAC_EN] & power_q[`PWR_DAC_BIT]; // RULE17
  assign pwm_on = config_q[`CFG_PWM_EN];

  always_comb begin
    // PWM always takes the pin the DAC driver does not use
    sm_src_d = pin_src(dac_on & !drv_large & sm_pwr, pwm_on & drv_large,
                       config_q[`CFG_SM_AMP_EN] & sm_pwr); // RULE8 RULE9 RULE12
    lg_src_d = pin_src(dac_on & drv_large & lg_pwr, pwm_on & !drv_large,
                       config_q[`CFG_LG_AMP_EN] & lg_pwr); // RULE7 RULE10 RULE12
    // DAC without a powered driver amp has nowhere to go
    if (dac_on && (drv_large ? !lg_pwr : !sm_pwr) && !pwm_on) begin
      sm_src_d = SRC_NONE; // RULE11
      lg_src_d = SRC_NONE;
    end
    // Controls: dac en, ref, sm en, sm buf, lg en, lg buf
    ctl_d[0] = dac_on; // RULE16 RULE17
    ctl_d[1] = config_q[`CFG_REF_EXT]; // RULE13
    ctl_d[2] = (sm_src_d == SRC_DAC) || (sm_src_d == SRC_AMP); // RULE8 RULE17
    ctl_d[3] = (sm_src_d == SRC_DAC) || config_q[`CFG_SM_BUF]; // RULE9 RULE14
    ctl_d[4] = (lg_src_d == SRC_DAC) || (lg_src_d == SRC_AMP); // RULE10 RULE17
    ctl_d[5] = (lg_src_d == SRC_DAC) || config_q[`CFG_LG_BUF]; // RULE7 RULE14
    sm_pwm_d = (sm_src_q == SRC_PWM) & pw.level;
    lg_pwm_d = (lg_src_q == SRC_PWM) & pw.level;
  end

  ////////////////////////////////////////////////////////////////////////
  // All state registers except the check counter gap_q
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      power_q <= `RST_POWER;
      data_q <= `RST_DATA;
      config_q <= `RST_CONFIG; // RULE19
      rdata_q <= 16'h0000;
      div_q <= 8'h00;
      step_q <= 1'b0;
      sm_src_q <= SRC_NONE;
      lg_src_q <= SRC_NONE;
      ctl_q <= 6'h00;
      sm_pwm_q <= 1'b0;
      lg_pwm_q <= 1'b0;
    end else begin
      power_q <= power_d;
      data_q <= data_d;
      config_q <= config_d;
      rdata_q <= rdata_d;
      div_q <= div_d;
      step_q <= step_d;
      sm_src_q <= sm_src_d;
      lg_src_q <= lg_src_d;
      ctl_q <= ctl_d;
      sm_pwm_q <= sm_pwm_d;
      lg_pwm_q <= lg_pwm_d;
    end
  end

  // Outputs, all from flip-flops
  assign reg_rdata = rdata_q;
  assign dac_code = data_q; // RULE16
  assign dac_enable = ctl_q[0];
  assign dac_ref_ext = ctl_q[1];
  assign sm_amp_enable = ctl_q[2];
  assign sm_amp_buffer = ctl_q[3];
  assign sm_amp_from_dac = (sm_src_q == SRC_DAC);
  assign amp_inverting_pin_sm_hiz = ctl_q[3] | !ctl_q[2]; // RULE14
  assign lg_amp_enable = ctl_q[4];
  assign lg_amp_buffer = ctl_q[5];
  assign lg_amp_from_dac = (lg_src_q == SRC_DAC);
  assign amp_inverting_pin_lg_hiz = ctl_q[5] | !ctl_q[4]; // RULE14
  assign small_amp_out_pin_src = sm_src_q;
  assign large_amp_out_pin_src = lg_src_q;
  assign small_amp_out_pin_pwm = sm_pwm_q;
  assign large_amp_out_pin_pwm = lg_pwm_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Cycles since the last step; a counter, as the spacing can exceed eight
  logic [7:0] gap_q, gap_d;
  always_comb begin
    gap_d = gap_q + 8'h01;
    if (!pwm_on) begin
      gap_d = 8'h00;
    end else if (step_q) begin
      gap_d = 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= gap_d;
    end
  end

  property p_step_spacing;
    @(posedge core_clk) disable iff (!nrst)
      pwm_on |-> (step_q == (gap_q == STEP_GAP));
  endproperty
  a_step_spacing: assert property (p_step_spacing) else $error("step spacing wrong"); // RULE5

  property p_rdata_config;
    @(posedge core_clk) disable iff (!nrst)
      (reg_addr == `ADDR_CONFIG) |=> (reg_rdata == $past(config_q));
  endproperty
  a_rdata_config: assert property (p_rdata_config) else $error("config readback wrong"); // RULE15

  property p_ref_select;
    @(posedge core_clk) disable iff (!nrst)
      1'b1 |=> (dac_ref_ext == $past(config_q[`CFG_REF_EXT]));
  endproperty
  a_ref_select: assert property (p_ref_select) else $error("reference select wrong"); // RULE13

  property p_sm_dac_buf;
    @(posedge core_clk) disable iff (!nrst)
      sm_amp_from_dac |-> (sm_amp_enable && sm_amp_buffer && amp_inverting_pin_sm_hiz);
  endproperty
  a_sm_dac_buf: assert property (p_sm_dac_buf) else $error("small dac driver not buffer"); // RULE9

  property p_lg_dac_buf;
    @(posedge core_clk) disable iff (!nrst)
      lg_amp_from_dac |-> (lg_amp_enable && lg_amp_buffer && amp_inverting_pin_lg_hiz);
  endproperty
  a_lg_dac_buf: assert property (p_lg_dac_buf) else $error("large dac driver not buffer"); // RULE7

  property p_sm_unpwr;
    @(posedge core_clk) disable iff (!nrst)
      !sm_pwr |=> !sm_amp_enable;
  endproperty
  a_sm_unpwr: assert property (p_sm_unpwr) else $error("unpowered small amp on"); // RULE17

  property p_lg_unpwr;
    @(posedge core_clk) disable iff (!nrst)
      !lg_pwr |=> !lg_amp_enable;
  endproperty
  a_lg_unpwr: assert property (p_lg_unpwr) else $error("unpowered large amp on"); // RULE17

  property p_sm_pwm_pin;
    @(posedge core_clk) disable iff (!nrst)
      small_amp_out_pin_pwm |-> $past(sm_src_q == SRC_PWM);
  endproperty
  a_sm_pwm_pin: assert property (p_sm_pwm_pin) else $error("pwm on unrouted pin"); // RULE8

  property p_pwm_small_pin;
    @(posedge core_clk) disable iff (!nrst)
      (dac_on && drv_large && lg_pwr && pwm_on)
        |=> (sm_src_q == SRC_PWM && !sm_amp_enable && lg_amp_buffer);
  endproperty
  a_pwm_small_pin: assert property (p_pwm_small_pin) else $error("bad small pin"); // RULE8

  property p_pwm_large_pin;
    @(posedge core_clk) disable iff (!nrst)
      (dac_on && !drv_large && sm_pwr && pwm_on)
        |=> (lg_src_q == SRC_PWM && !lg_amp_enable && sm_amp_buffer);
  endproperty
  a_pwm_large_pin: assert property (p_pwm_large_pin) else $error("bad large pin"); // RULE10

  property p_no_conflict;
    @(posedge core_clk) disable iff (!nrst)
      !(sm_src_q == lg_src_q && (sm_src_q == SRC_DAC || sm_src_q == SRC_PWM));
  endproperty
  a_no_conflict: assert property (p_no_conflict) else $error("function on both pins"); // RULE12

  property p_dac_off;
    @(posedge core_clk) disable iff (!nrst)
      !power_q[`PWR_DAC_BIT] |=> (!dac_enable && sm_src_q != SRC_DAC && lg_src_q != SRC_DAC);
  endproperty
  a_dac_off: assert property (p_dac_off) else $error("unpowered dac routed"); // RULE17

  property p_reset_idle;
    @(posedge core_clk) !nrst |=> (sm_src_q == SRC_NONE && lg_src_q == SRC_NONE
                                  && !small_amp_out_pin_pwm && !large_amp_out_pin_pwm);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pins driven after reset"); // RULE19

  c_dac_and_pwm: cover property (@(posedge core_clk) disable iff (!nrst)
    sm_src_q == SRC_PWM && lg_src_q == SRC_DAC);
  c_dac_and_amp: cover property (@(posedge core_clk) disable iff (!nrst)
    sm_src_q == SRC_AMP && lg_src_q == SRC_DAC);
  c_pwm_and_amp: cover property (@(posedge core_clk) disable iff (!nrst)
    lg_src_q == SRC_PWM && sm_src_q == SRC_AMP);
endmodule

// ### rtl/pwm_core.sv
/*
  Twelve-bit PWM core: free-running step counter, duty held per period.
  Assumes a one-cycle step enable and a two's complement duty word.
*/
`timescale 1ns/1ns
`include "dop_regs.svh"
module pwm_core
  import dop_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  pwm_if.core pw
);
  logic [11:0] cnt_q, cnt_d;
  logic [11:0] duty_q, duty_d;
  logic level_q, level_d;

  ////////////////////////////////////////////////////////////////////////
  // Next-state: counter, period-boundary duty latch, output level
  always_comb begin
    cnt_d = cnt_q;
    duty_d = duty_q;
    level_d = 1'b0;
    if (!pw.enable) begin
      // Idle: next enable starts a clean period with the fresh word
      cnt_d = 12'h000;
      duty_d = pw.duty_word ^ `PWM_MID; // RULE1
    end else if (pw.step) begin
      cnt_d = cnt_q + 12'h001; // RULE18
      if (cnt_q == 12'hFFF) begin
        duty_d = pw.duty_word ^ `PWM_MID; // RULE6
      end
    end
    // Offset binary compare covers zero, half and 4095 high steps; kept
    // running while idle so the first enabled cycle already agrees
    level_d = ({1'b0, cnt_d} < {1'b0, duty_d}); // RULE2 RULE3 RULE4 RULE18
  end

  // Registers only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_q <= 12'h000;
      duty_q <= `PWM_MID;
      level_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      duty_q <= duty_d;
      level_q <= level_d;
    end
  end

  // Gated so a disabled PWM never reports a high level
  assign pw.level = level_q & pw.enable; // RULE19

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_zero_duty_low;
    @(posedge core_clk) disable iff (!nrst) (duty_q == 12'h000) |-> !level_q;
  endproperty
  a_zero_duty_low: assert property (p_zero_duty_low) else $error("min duty went high"); // RULE3

  property p_full_duty_high;
    @(posedge core_clk) disable iff (!nrst)
      (pw.enable && duty_q == 12'hFFF && cnt_q != 12'hFFF) |-> level_q;
  endproperty
  a_full_duty_high: assert property (p_full_duty_high) else $error("max duty low"); // RULE4

  property p_half_duty;
    @(posedge core_clk) disable iff (!nrst)
      (pw.enable && duty_q == 12'h800) |-> (level_q == !cnt_q[11]);
  endproperty
  a_half_duty: assert property (p_half_duty) else $error("mid code not half"); // RULE2

  property p_duty_held;
    @(posedge core_clk) disable iff (!nrst)
      ($past(pw.enable) && pw.enable && duty_q != $past(duty_q))
        |-> $past(pw.step && cnt_q == 12'hFFF);
  endproperty
  a_duty_held: assert property (p_duty_held) else $error("duty changed mid period"); // RULE6

  property p_compare;
    @(posedge core_clk) disable iff (!nrst)
      pw.enable |-> (level_q == (cnt_q < duty_q));
  endproperty
  a_compare: assert property (p_compare) else $error("level disagrees with count"); // RULE18

  c_wrap: cover property (@(posedge core_clk) disable iff (!nrst)
    pw.step && cnt_q == 12'hFFF);
endmodule

// ### shared/dop_pkg.sv
/*
  Types shared by the output module and its PWM core.
  Assumes nothing beyond the register header.
*/
package dop_pkg;
  // What a module output pin carries
  typedef enum logic [1:0] {SRC_NONE, SRC_DAC, SRC_PWM, SRC_AMP} pin_src_t;
endpackage

// ### shared/dop_regs.svh
/*
  Register addresses, field positions, reset values and timing counts
  for the output module. Assumes a 50 MHz core clock.
*/
`ifndef DOP_REGS_SVH
`define DOP_REGS_SVH

// Register addresses on the CPU port
`define ADDR_POWER_ON 8'h31
`define ADDR_DATA_WORD 8'h38
`define ADDR_CONFIG 8'h39
`define ADDR_STATUS 8'h3A

// Power-on control bits
`define PWR_DAC_BIT 0
`define PWR_SM_AMP_BIT 1
`define PWR_LG_AMP_BIT 2

// Module configuration bits
`define CFG_DAC_EN 0
`define CFG_PWM_EN 1
`define CFG_DRV_LARGE 2
`define CFG_REF_EXT 3
`define CFG_SM_BUF 4
`define CFG_LG_BUF 5
`define CFG_SM_AMP_EN 6
`define CFG_LG_AMP_EN 7

// Reset values
`define RST_POWER 16'h0000
`define RST_DATA 16'h0000
`define RST_CONFIG 16'h0000

// Timing: one PWM step is 2 us, rounded up to whole core cycles
`define CLK_PERIOD_NS 20
`define PWM_STEP_NS 2000
`define PWM_STEP_CYC ((`PWM_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWM_MID 12'h800

`endif

// ### shared/pwm_if.sv
/*
  Carrier between the output module and its PWM core.
  Assumes both ends share core_clk.
*/
`timescale 1ns/1ns
interface pwm_if;
  logic step;
  logic enable;
  logic [11:0] duty_word;
  logic level;
  modport core (input step, input enable, input duty_word, output level);
  modport user (output step, output enable, output duty_word, input level);
endinterface

// ### test/dop_load_model.sv
/*
  Load on one module output pin: counts core cycles in which the pin
  carries the PWM and that PWM is high.
  Assumes the pin source and PWM level are registered on core_clk.
*/
`timescale 1ns/1ns
module dop_load_model
  import dop_pkg::*;
(
  input wire logic core_clk,
  input wire logic clr,
  input wire pin_src_t pin_src,
  input wire logic pin_pwm,
  output logic [15:0] high_cnt
);
  ////////////////////////////////////////////////////////////////////
  // High time seen by the load; a non-PWM pin never counts
  always_ff @(posedge core_clk) begin
    if (clr) begin
      high_cnt <= 16'h0000;
    end else if (pin_src == SRC_PWM && pin_pwm) begin
      high_cnt <= high_cnt + 16'h0001;
    end
  end
endmodule

// ### test/tb.sv
/*
  Self-checking bench for the output module: reset state, register
  port, routing table and PWM duty.
  Assumes STEP_CYC shortened to 2 so one period is 8192 cycles.
*/
`timescale 1ns/1ns
`include "dop_regs.svh"
module tb;
  import dop_pkg::*;
  localparam int STEP = 2;
  localparam int PER = 4096 * STEP;
  typedef struct packed {
    logic [2:0] pwr;
    logic [7:0] cfg;
    pin_src_t sm;
    pin_src_t lg;
    logic [5:0] fl;
  } row_t;
  logic core_clk, nrst, reg_wr, clr;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, dac_code, hi_lg;
  logic dac_enable, dac_ref_ext, sm_amp_enable, sm_amp_buffer, sm_amp_from_dac;
  logic amp_inverting_pin_sm_hiz, lg_amp_enable, lg_amp_buffer, lg_amp_from_dac;
  logic amp_inverting_pin_lg_hiz, small_amp_out_pin_pwm, large_amp_out_pin_pwm;
  pin_src_t small_amp_out_pin_src, large_amp_out_pin_src;
  pin_src_t load_src;
  logic load_pwm, pin_sel;
  int errors, checks_done;
  // Flags: dac_en, ref_ext, sm_en, lg_en, sm_buf, sm_inv_hiz
  row_t rows [12] = '{
    '{3'h7, 8'h05, SRC_NONE, SRC_DAC, 6'h25},
    '{3'h7, 8'h07, SRC_PWM, SRC_DAC, 6'h25},
    '{3'h7, 8'h45, SRC_AMP, SRC_DAC, 6'h2C},
    '{3'h7, 8'h01, SRC_DAC, SRC_NONE, 6'h2B},
    '{3'h7, 8'h03, SRC_DAC, SRC_PWM, 6'h2B},
    '{3'h7, 8'h81, SRC_DAC, SRC_AMP, 6'h2F},
    '{3'h7, 8'h83, SRC_DAC, SRC_PWM, 6'h2B},
    '{3'h7, 8'hC4, SRC_AMP, SRC_AMP, 6'h0C},
    '{3'h0, 8'h05, SRC_NONE, SRC_NONE, 6'h01},
    '{3'h7, 8'hD6, SRC_PWM, SRC_AMP, 6'h07},
    '{3'h7, 8'h0D, SRC_NONE, SRC_DAC, 6'h35},
    '{3'h7, 8'h50, SRC_AMP, SRC_NONE, 6'h0B}
  };

  dop_output_module #(.STEP_CYC(STEP)) u_dop_output_module (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .dac_code(dac_code),
    .dac_enable(dac_enable), .dac_ref_ext(dac_ref_ext), .sm_amp_enable(sm_amp_enable),
    .sm_amp_buffer(sm_amp_buffer), .sm_amp_from_dac(sm_amp_from_dac),
    .amp_inverting_pin_sm_hiz(amp_inverting_pin_sm_hiz), .lg_amp_enable(lg_amp_enable),
    .lg_amp_buffer(lg_amp_buffer), .lg_amp_from_dac(lg_amp_from_dac),
    .amp_inverting_pin_lg_hiz(amp_inverting_pin_lg_hiz),
    .small_amp_out_pin_src(small_amp_out_pin_src),
    .large_amp_out_pin_src(large_amp_out_pin_src),
    .small_amp_out_pin_pwm(small_amp_out_pin_pwm),
    .large_amp_out_pin_pwm(large_amp_out_pin_pwm));

  // Load sits on whichever pin the duty scenario routes the PWM to
  always_comb begin
    load_src = large_amp_out_pin_src;
    load_pwm = large_amp_out_pin_pwm;
    if (pin_sel) begin
      load_src = small_amp_out_pin_src;
      load_pwm = small_amp_out_pin_pwm;
    end
  end
  dop_load_model u_dop_load_model (.core_clk(core_clk), .clr(clr),
    .pin_src(load_src), .pin_pwm(load_pwm), .high_cnt(hi_lg));

  ////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Outputs sampled 2 ns after the edge so its updates have landed
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wt(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    wt(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    wt(1);
    reg_addr = a;
    wt(1);
    chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic chk_idle();
    chk("small src", 16'(SRC_NONE), 16'(small_amp_out_pin_src));
    chk("large src", 16'(SRC_NONE), 16'(large_amp_out_pin_src));
    chk("pwm pins", 16'h0000, {14'h0000, small_amp_out_pin_pwm, large_amp_out_pin_pwm});
    rd(`ADDR_POWER_ON, 16'h0000);
    rd(`ADDR_CONFIG, 16'h0000);
  endtask
  // One full period window: a constant duty gives an exact count
  task automatic duty(input logic [15:0] d, input logic [15:0] exp);
    wr(`ADDR_CONFIG, 16'h0000);
    wr(`ADDR_DATA_WORD, d);
    wr(`ADDR_CONFIG, pin_sel ? 16'h0006 : 16'h0002);
    wt(20);
    clr = 1'b1;
    wt(1);
    clr = 1'b0;
    wt(PER);
    chk("pwm high cycles", exp, hi_lg);
  endtask
  task automatic final_report();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Clock, 50 MHz
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Watchdog well beyond the seven PWM periods the run needs
  initial begin
    #(90000 * 20);
    errors++;
    final_report();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    clr = 1'b0;
    pin_sel = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    wt(16);
    nrst = 1'b1;
    chk_idle();
    wr(`ADDR_POWER_ON, 16'hFFFF);
    rd(`ADDR_POWER_ON, 16'hFFFF);
    wr(8'h50, 16'h1234);
    rd(8'h50, 16'h0000);
    wr(`ADDR_DATA_WORD, 16'h8000);
    rd(`ADDR_DATA_WORD, 16'h8000);
    chk("dac_code", 16'h8000, dac_code);
    // Routing table
    foreach (rows[i]) begin
      wr(`ADDR_POWER_ON, {13'h0000, rows[i].pwr});
      wr(`ADDR_CONFIG, {8'h00, rows[i].cfg});
      wt(3);
      chk("small src", 16'(rows[i].sm), 16'(small_amp_out_pin_src));
      chk("large src", 16'(rows[i].lg), 16'(large_amp_out_pin_src));
      chk("flags", {10'h000, rows[i].fl}, {10'h000, dac_enable, dac_ref_ext,
        sm_amp_enable, lg_amp_enable, sm_amp_buffer, amp_inverting_pin_sm_hiz});
      chk("from dac", {14'h0000, rows[i].sm == SRC_DAC, rows[i].lg == SRC_DAC},
        {14'h0000, sm_amp_from_dac, lg_amp_from_dac});
      chk("lg buf hiz", {14'h0000, (rows[i].lg == SRC_DAC) || rows[i].cfg[`CFG_LG_BUF],
        !(rows[i].lg == SRC_AMP && !rows[i].cfg[`CFG_LG_BUF])},
        {14'h0000, lg_amp_buffer, amp_inverting_pin_lg_hiz});
    end
    wr(`ADDR_POWER_ON, 16'h0007);
    wr(`ADDR_CONFIG, 16'h0005);
    wt(3);
    chk("lg buffer", 16'h0001, {15'h0000, lg_amp_buffer});
    // Status: large src DAC, small src none, PWM idle; writes refused
    rd(`ADDR_STATUS, 16'h0010);
    wr(`ADDR_STATUS, 16'hFFFF);
    rd(`ADDR_STATUS, 16'h0010);
    // PWM duty, low nibble ignored, scaled by the step length
    duty(16'h0000, 16'(2048 * STEP));
    duty(16'h8000, 16'h0000);
    duty(16'h7FF5, 16'(4095 * STEP));
    duty(16'h0010, 16'(2049 * STEP));
    duty(16'hFFF0, 16'(2047 * STEP));
    // Large amp selected as DAC driver (DAC left off) sends the PWM to the small pin
    pin_sel = 1'b1;
    duty(16'h4000, 16'(3072 * STEP));
    pin_sel = 1'b0;
    // New word mid-period must wait for the wrap
    wr(`ADDR_CONFIG, 16'h0000);
    wr(`ADDR_DATA_WORD, 16'h8000);
    wr(`ADDR_CONFIG, 16'h0002);
    wt(100);
    wr(`ADDR_DATA_WORD, 16'h7FF0);
    clr = 1'b1;
    wt(1);
    clr = 1'b0;
    wt(PER - 300);
    chk("old duty kept", 16'h0000, hi_lg);
    wt(400);
    chk("new duty", 16'h0001, {15'h0000, large_amp_out_pin_pwm});
    // Second reset mid-run
    nrst = 1'b0;
    wt(2);
    nrst = 1'b1;
    chk_idle();
    final_report();
  end
endmodule
